//--- src/kswd_core.v
// Purpose: Keyed service watchdog with window, interrupt-first and hard-lock.
// Assumes: ref_clk_i is the internal RC clock; all inputs are synchronous.
// Notes: Configuration writes are one-cycle strobes that load every field unless hard-lock is set.
`timescale 1ns/10ps
`default_nettype none
`include "kswd_defines.vh"

module kswd_core (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire cfg_wr_i,
  input wire cfg_en_i,
  input wire cfg_hard_lock_bit_i,
  input wire cfg_irq_first_i,
  input wire cfg_window_en_i,
  input wire cfg_keyed_i,
  input wire [`KSWD_CNT_W-1:0] cfg_timeout_i,
  input wire [`KSWD_CNT_W-1:0] cfg_window_i,
  input wire [`KSWD_KEY_W-1:0] cfg_key_i,
  input wire svc_wr_i,
  input wire [`KSWD_KEY_W-1:0] svc_data_i,
  output reg ctrl_en_o,
  output reg ctrl_hard_lock_bit_o,
  output reg ctrl_irq_first_o,
  output reg ctrl_window_en_o,
  output reg ctrl_keyed_o,
  output reg [`KSWD_CNT_W-1:0] timeout_period_reg_o,
  output reg [`KSWD_CNT_W-1:0] window_reg_o,
  output reg [`KSWD_KEY_W-1:0] service_key_o,
  output reg [`KSWD_CNT_W-1:0] count_o,
  output reg irq_o,
  output reg fault_collector_o,
  output reg cfg_reject_o,
  output reg svc_error_o,
  output reg svc_done_o
);

  // Service sequence states.
  localparam ST_IDLE = `KSWD_ST_IDLE;
  localparam ST_HALF = `KSWD_ST_HALF;

  reg [`KSWD_ST_W-1:0] state_q;
  reg [`KSWD_ST_W-1:0] state_d;
  wire [`KSWD_KEY_W-1:0] next_key;
  wire cfg_take;
  wire win_open;
  wire expired;
  reg svc_ok;
  reg svc_bad;
  reg key_adv;
  reg [`KSWD_KEY_W-1:0] expect_val;
  reg [`KSWD_KEY_W-1:0] key_d;
  reg [`KSWD_CNT_W-1:0] count_d;
  reg [`KSWD_CNT_W-1:0] timeout_d;
  reg [`KSWD_CNT_W-1:0] window_d;
  reg en_d;
  reg lock_d;
  reg irq_first_d;
  reg win_en_d;
  reg keyed_d;
  reg irq_d;
  reg fault_d;
  wire svc_done_d;
  wire svc_error_d;

  kswd_keygen u_keygen (
    .key_i(service_key_o),
    .next_key_o(next_key)
  );

  // The hard-lock also blocks its own write, so it cannot be cleared.
  assign cfg_take = cfg_wr_i && !ctrl_hard_lock_bit_o; // [R04] [R15]

  // The window opens once the counter has fallen to the window value.
  assign win_open = !ctrl_window_en_o || (count_o <= window_reg_o); // [R14]

  assign expired = ctrl_en_o && (count_o == `KSWD_CNT_RST);

  // Service decoder: which value is expected for the current step.
  always @* begin
    state_d = state_q;
    svc_ok = 1'b0;
    svc_bad = 1'b0;
    key_adv = 1'b0;
    expect_val = service_key_o;
    if (!ctrl_keyed_o) begin
      if (state_q == ST_IDLE) begin
        expect_val = `KSWD_FIX_FIRST; // [R07]
      end else begin
        expect_val = `KSWD_FIX_SECOND; // [R07]
      end
    end
    if (svc_wr_i && ctrl_en_o) begin
      if (!win_open || svc_data_i != expect_val) begin
        // A bad write aborts the sequence and leaves the counter alone.
        svc_bad = 1'b1; // [R14] [R09]
        state_d = ST_IDLE;
      end else begin
        key_adv = ctrl_keyed_o; // [R10] [R12]
        case (state_q)
          ST_IDLE: begin
            state_d = ST_HALF;
          end
          ST_HALF: begin
            state_d = ST_IDLE;
            svc_ok = 1'b1; // [R08] [R12]
          end
          default: begin
            state_d = ST_IDLE;
          end
        endcase
      end
    end
  end

  // A config write in the same cycle wins, so no service pulse is shown.
  assign svc_done_d = svc_ok && !cfg_take; // [R08]
  assign svc_error_d = svc_bad && !cfg_take; // [R14]

  // Configuration next values; a refused write leaves every field alone.
  always @* begin
    en_d = ctrl_en_o;
    lock_d = ctrl_hard_lock_bit_o;
    irq_first_d = ctrl_irq_first_o;
    win_en_d = ctrl_window_en_o;
    keyed_d = ctrl_keyed_o;
    timeout_d = timeout_period_reg_o;
    window_d = window_reg_o;
    if (cfg_take) begin
      en_d = cfg_en_i; // [R06]
      lock_d = cfg_hard_lock_bit_i; // [R04]
      irq_first_d = cfg_irq_first_i; // [R02]
      win_en_d = cfg_window_en_i; // [R14]
      keyed_d = cfg_keyed_i; // [R09]
      timeout_d = cfg_timeout_i; // [R05]
      window_d = cfg_window_i; // [R14]
    end
  end

  // Configuration and control bits, readable on the ctrl outputs.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_en_o <= 1'b0;
      ctrl_hard_lock_bit_o <= 1'b0;
      ctrl_irq_first_o <= 1'b0;
      ctrl_window_en_o <= 1'b0;
      ctrl_keyed_o <= 1'b0;
      timeout_period_reg_o <= `KSWD_TO_RST;
      window_reg_o <= `KSWD_WIN_RST;
      cfg_reject_o <= 1'b0;
    end else begin
      cfg_reject_o <= cfg_wr_i && ctrl_hard_lock_bit_o; // [R04]
      ctrl_en_o <= en_d; // [R06]
      ctrl_hard_lock_bit_o <= lock_d; // [R04] [R15]
      ctrl_irq_first_o <= irq_first_d;
      ctrl_window_en_o <= win_en_d;
      ctrl_keyed_o <= keyed_d;
      timeout_period_reg_o <= timeout_d; // [R05]
      window_reg_o <= window_d;
    end
  end

  // Expected key: reseeded by a config write, advanced by a good key write.
  always @* begin
    key_d = service_key_o;
    if (cfg_take) begin
      key_d = cfg_key_i;
    end else if (key_adv) begin
      key_d = next_key; // [R10] [R11]
    end
  end

  // Service sequencer; reconfiguring restarts the sequence at step one.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_q <= ST_IDLE;
      service_key_o <= `KSWD_KEY_RST;
      svc_error_o <= 1'b0;
      svc_done_o <= 1'b0;
    end else begin
      svc_error_o <= svc_error_d; // [R14]
      svc_done_o <= svc_done_d; // [R08]
      service_key_o <= key_d; // [R10]
      if (cfg_take) begin
        state_q <= ST_IDLE;
      end else begin
        state_q <= state_d;
      end
    end
  end

  // Down-counter next state; ref_clk_i is the internal RC clock in every
  // system mode, so a stalled system clock cannot freeze the count.
  always @* begin // [R13]
    count_d = count_o;
    irq_d = irq_o;
    fault_d = fault_collector_o;
    if (cfg_take) begin
      count_d = cfg_timeout_i; // [R05]
      irq_d = 1'b0;
    end else if (!ctrl_en_o) begin
      count_d = timeout_period_reg_o;
    end else if (svc_ok) begin
      // A good service also clears a pending first timeout.
      count_d = timeout_period_reg_o; // [R08]
      irq_d = 1'b0;
    end else if (expired) begin
      if (ctrl_irq_first_o && !irq_o) begin
        irq_d = 1'b1; // [R02]
        count_d = timeout_period_reg_o; // [R02]
      end else begin
        // Fault is sticky until reset; the counter stops at zero.
        fault_d = 1'b1; // [R02] [R03]
      end
    end else begin
      count_d = count_o - `KSWD_CNT_ONE;
    end
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin // [R13]
    if (!rst_b_i) begin
      count_o <= `KSWD_TO_RST;
      irq_o <= 1'b0;
      fault_collector_o <= 1'b0;
    end else begin
      count_o <= count_d;
      irq_o <= irq_d;
      fault_collector_o <= fault_d;
    end
  end

endmodule // kswd_core
`default_nettype wire

//--- src/kswd_defines.vh
// Purpose: Constants shared by the keyed service watchdog design files.
// Assumes: One clock, the internal RC clock, drives all logic.
// Notes: Definitions only; included by bare name.
//
// Overview of operation
// R01: Software services the enabled watchdog periodically, inside its window, before timeout.
// R02: On timeout, raise fault at once, or interrupt and reload the counter.
// R03: In interrupt-first mode a second consecutive timeout raises the fault output.
// R04: Control holds enable and hard-lock; hard-lock makes configuration reject writes.
// R05: Timeout period is a 32-bit reload value in watchdog clock cycles.
// R06: Control bits are readable so software can confirm the enable bit.
// R07: Fixed service is two consecutive writes, A602h then B480h.
// R08: A complete correct service reloads the down-counter with the timeout period.
// R09: Keyed service refreshes only when the written key equals the computed key.
// R10: Keyed service computes a new expected key after each accepted key write.
// R11: Key is 16 bits; next key is 17 times (key plus 3) modulo 2^16.
// R12: Keyed service consists of two key writes, both checked against computed keys.
// R13: The down-counter always runs on the internal RC clock.
// R14: Wrong value, wrong key, or write outside an enabled window never reloads.
// R15: Hard-lock stays set until reset; software cannot clear it.
`ifndef KSWD_DEFINES_VH
`define KSWD_DEFINES_VH

`define KSWD_CNT_W 32
`define KSWD_KEY_W 16
`define KSWD_FIX_FIRST 16'hA602
`define KSWD_FIX_SECOND 16'hB480
`define KSWD_KEY_MUL 16'h0011
`define KSWD_KEY_ADD 16'h0003
`define KSWD_KEY_RST 16'h0000
`define KSWD_CNT_RST 32'h0000_0000
`define KSWD_CNT_ONE 32'h0000_0001
`define KSWD_TO_RST 32'h0000_FFFF
`define KSWD_WIN_RST 32'h0000_0000
`define KSWD_ST_W 1
`define KSWD_ST_IDLE 1'b0
`define KSWD_ST_HALF 1'b1

`endif

//--- src/kswd_keygen.v
// Purpose: Next service key from the current one.
// Assumes: Pure combinational; the caller registers the result.
// Notes: The product is formed at twice the key width; only its low half is kept.
`timescale 1ns/10ps
`default_nettype none
`include "kswd_defines.vh"

module kswd_keygen (
  input wire [`KSWD_KEY_W-1:0] key_i,
  output wire [`KSWD_KEY_W-1:0] next_key_o
);

  wire [`KSWD_KEY_W:0] sum_full;
  wire [`KSWD_KEY_W-1:0] sum;
  wire [2*`KSWD_KEY_W-1:0] prod;

  // The carry is dropped on purpose, since the key arithmetic wraps.
  assign sum_full = {1'b0, key_i} + {1'b0, `KSWD_KEY_ADD}; // [R11]
  assign sum = sum_full[`KSWD_KEY_W-1:0]; // [R11]
  // Only the low half is kept, which is the modulo 2^16 reduction.
  assign prod = sum * `KSWD_KEY_MUL; // [R11]
  assign next_key_o = prod[`KSWD_KEY_W-1:0]; // [R11]

endmodule // kswd_keygen
`default_nettype wire

//--- testbench/kswd_core_asserts.sv
// Purpose: Port assertions for the watchdog core.
// Assumes: One clock domain, reset active low.
// Notes: Bound to every core instance.
`timescale 1ns/10ps
`default_nettype none
module kswd_chk (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic cfg_wr_i,
  input wire logic svc_wr_i,
  input wire logic ctrl_en_o,
  input wire logic ctrl_hard_lock_bit_o,
  input wire logic ctrl_irq_first_o,
  input wire logic ctrl_keyed_o,
  input wire logic [31:0] timeout_period_reg_o,
  input wire logic [15:0] service_key_o,
  input wire logic [31:0] count_o,
  input wire logic irq_o,
  input wire logic fault_collector_o,
  input wire logic cfg_reject_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_exp;
    ctrl_en_o && count_o == 32'h0000_0000 && !svc_wr_i && !cfg_wr_i;
  endsequence
  property p_rej;
    cfg_wr_i && ctrl_hard_lock_bit_o |=> cfg_reject_o && $stable(ctrl_en_o);
  endproperty
  a_rej: assert property (p_rej) else $error("locked write taken");
  property p_hlk; ctrl_hard_lock_bit_o |=> ctrl_hard_lock_bit_o; endproperty
  a_hlk: assert property (p_hlk) else $error("lock lost");
  property p_dec;
    ctrl_en_o && count_o != 32'h0000_0000 && !svc_wr_i && !cfg_wr_i
      |=> count_o == $past(count_o) - 32'h0000_0001;
  endproperty
  a_dec: assert property (p_dec) else $error("bad count step");
  property p_irq;
    s_exp ##0 (ctrl_irq_first_o && !irq_o)
      |=> irq_o && count_o == timeout_period_reg_o;
  endproperty
  a_irq: assert property (p_irq) else $error("no irq reload");
  property p_flt;
    s_exp ##0 (irq_o || !ctrl_irq_first_o) |=> fault_collector_o;
  endproperty
  a_flt: assert property (p_flt) else $error("no fault");
  property p_stk; fault_collector_o |=> fault_collector_o; endproperty
  a_stk: assert property (p_stk) else $error("fault dropped");
  property p_key;
    ctrl_keyed_o && !$past(cfg_wr_i) && service_key_o != $past(service_key_o)
      |-> service_key_o == ($past(service_key_o) + 16'h0003) * 16'h0011;
  endproperty
  a_key: assert property (p_key) else $error("bad key step");
  property p_cfg;
    cfg_wr_i && !ctrl_hard_lock_bit_o
      |=> !irq_o && count_o == timeout_period_reg_o;
  endproperty
  a_cfg: assert property (p_cfg) else $error("no cfg load");
endmodule // kswd_chk
bind kswd_core kswd_chk u_kswd_chk (
  .ref_clk_i(ref_clk_i),
  .rst_b_i(rst_b_i),
  .cfg_wr_i(cfg_wr_i),
  .svc_wr_i(svc_wr_i),
  .ctrl_en_o(ctrl_en_o),
  .ctrl_hard_lock_bit_o(ctrl_hard_lock_bit_o),
  .ctrl_irq_first_o(ctrl_irq_first_o),
  .ctrl_keyed_o(ctrl_keyed_o),
  .timeout_period_reg_o(timeout_period_reg_o),
  .service_key_o(service_key_o),
  .count_o(count_o),
  .irq_o(irq_o),
  .fault_collector_o(fault_collector_o),
  .cfg_reject_o(cfg_reject_o)
);
`default_nettype wire

//--- testbench/kswd_sink.sv
// Purpose: Model of the interrupt logic side.
// Assumes: The watchdog interrupt is a level.
// Notes: Remembers any interrupt until reset.
`timescale 1ns/10ps
`default_nettype none
module kswd_sink (
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic irq_i,
  output logic irq_seen_o
);
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) irq_seen_o <= 1'b0;
    else irq_seen_o <= irq_seen_o | irq_i;
  end
endmodule // kswd_sink
`default_nettype wire

//--- testbench/tb_keyed_service_watchdog.sv
// Purpose: Directed bench for the watchdog core.
// Assumes: Timeout of 20 clocks and window of 5 keep the run short.
// Notes: Fault is sticky, so each run starts from reset.
`timescale 1ns/10ps
`default_nettype none
module tb_keyed_service_watchdog;
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, cfg_wr_i = 1'b0, svc_wr_i = 1'b0;
  logic cfg_en_i = 1'b0, cfg_hard_lock_bit_i = 1'b0, cfg_irq_first_i = 1'b0;
  logic cfg_window_en_i = 1'b0, cfg_keyed_i = 1'b0, irq_seen;
  logic [31:0] cfg_timeout_i = 32'h0000_0014, cfg_window_i = 32'h0000_0005;
  logic [15:0] cfg_key_i = 16'h1234, svc_data_i = 16'h0000, service_key_o;
  logic ctrl_en_o, ctrl_hard_lock_bit_o, ctrl_irq_first_o, ctrl_window_en_o;
  logic ctrl_keyed_o, irq_o, fault_collector_o, cfg_reject_o, svc_error_o;
  logic svc_done_o;
  logic [31:0] timeout_period_reg_o, window_reg_o, count_o;
  int err_total = 0, samples_checked = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  kswd_core u_kswd_core (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .cfg_wr_i(cfg_wr_i),
    .cfg_en_i(cfg_en_i),
    .cfg_hard_lock_bit_i(cfg_hard_lock_bit_i),
    .cfg_irq_first_i(cfg_irq_first_i),
    .cfg_window_en_i(cfg_window_en_i),
    .cfg_keyed_i(cfg_keyed_i),
    .cfg_timeout_i(cfg_timeout_i),
    .cfg_window_i(cfg_window_i),
    .cfg_key_i(cfg_key_i),
    .svc_wr_i(svc_wr_i),
    .svc_data_i(svc_data_i),
    .ctrl_en_o(ctrl_en_o),
    .ctrl_hard_lock_bit_o(ctrl_hard_lock_bit_o),
    .ctrl_irq_first_o(ctrl_irq_first_o),
    .ctrl_window_en_o(ctrl_window_en_o),
    .ctrl_keyed_o(ctrl_keyed_o),
    .timeout_period_reg_o(timeout_period_reg_o),
    .window_reg_o(window_reg_o),
    .service_key_o(service_key_o),
    .count_o(count_o),
    .irq_o(irq_o),
    .fault_collector_o(fault_collector_o),
    .cfg_reject_o(cfg_reject_o),
    .svc_error_o(svc_error_o),
    .svc_done_o(svc_done_o)
  );
  kswd_sink u_kswd_sink (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .irq_i(irq_o),
    .irq_seen_o(irq_seen)
  );
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic rst();
    @(posedge ref_clk_i) rst_b_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    #1;
  endtask
  task automatic cfg(input logic [4:0] m);
    @(posedge ref_clk_i);
    {cfg_en_i, cfg_hard_lock_bit_i, cfg_irq_first_i, cfg_window_en_i,
      cfg_keyed_i} <= m;
    cfg_wr_i <= 1'b1;
    @(posedge ref_clk_i) cfg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic svc(input logic [15:0] d);
    @(posedge ref_clk_i);
    svc_wr_i <= 1'b1;
    svc_data_i <= d;
    @(posedge ref_clk_i) svc_wr_i <= 1'b0;
    #1;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return (x + 16'h0003) * 16'h0011;
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    $display("[FAIL] %0t run did not finish in time", $time);
    results();
  end
  initial begin
    rst();
    chk(count_o, 32'h0000_FFFF);
    cfg(5'h14);
    chk(ctrl_en_o, 1'b1);
    chk(ctrl_irq_first_o, 1'b1);
    chk(timeout_period_reg_o, 32'h0000_0014);
    svc(16'hB480);
    chk(svc_error_o, 1'b1);
    svc(16'hA602);
    svc(16'hB480);
    chk(svc_done_o, 1'b1);
    chk(count_o, 32'h0000_0014);
    repeat (40) if (irq_o !== 1'b1) @(negedge ref_clk_i);
    chk(irq_o, 1'b1);
    chk(count_o, 32'h0000_0014);
    repeat (40) if (fault_collector_o !== 1'b1) @(negedge ref_clk_i);
    chk(fault_collector_o, 1'b1);
    chk(irq_seen, 1'b1);
    rst();
    cfg(5'h11);
    chk(ctrl_keyed_o, 1'b1);
    svc(16'h1235);
    chk(svc_error_o, 1'b1);
    svc(16'h1234);
    chk(service_key_o, nxt(16'h1234));
    svc(nxt(16'h1234));
    chk(svc_done_o, 1'b1);
    cfg(5'h1A);
    chk(ctrl_window_en_o, 1'b1);
    chk(window_reg_o, 32'h0000_0005);
    svc(16'hA602);
    chk(svc_error_o, 1'b1);
    cfg(5'h00);
    chk(cfg_reject_o, 1'b1);
    chk(ctrl_hard_lock_bit_o, 1'b1);
    chk(ctrl_en_o, 1'b1);
    repeat (40) if (count_o > 32'h0000_0005) @(negedge ref_clk_i);
    svc(16'hA602);
    svc(16'hB480);
    chk(svc_done_o, 1'b1);
    chk(count_o, 32'h0000_0014);
    repeat (40) if (fault_collector_o !== 1'b1) @(negedge ref_clk_i);
    chk(fault_collector_o, 1'b1);
    chk(irq_seen, 1'b0);
    results();
  end
endmodule // tb_keyed_service_watchdog
`default_nettype wire
